// File: rtl/bcce_pkg.sv
// Package of addresses, bit positions and reset values for the bay and clock control ports.
package bcce_pkg;

  // ----------------------------------------
  // Port addresses on the two private buses
  // ----------------------------------------
  localparam logic [6:0] ADDR_BAY1 = 7'h18;   // 8-bit form 0x30.
  localparam logic [6:0] ADDR_BAY2 = 7'h19;   // 8-bit form 0x32.
  localparam logic [6:0] ADDR_BAY3 = 7'h1a;   // 8-bit form 0x34.
  localparam logic [6:0] ADDR_BAY4 = 7'h1b;   // 8-bit form 0x36.
  localparam logic [6:0] ADDR_REAR = 7'h1c;   // 8-bit form 0x38.
  localparam logic [6:0] ADDR_CLK1 = 7'h1c;   // 8-bit form 0x38, on the other bus.
  localparam logic [6:0] ADDR_CLK2 = 7'h1d;   // 8-bit form 0x3a.
  localparam logic [6:0] ADDR_CLK3 = 7'h1e;   // 8-bit form 0x3c.

  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int BIT_BP_A = 0;
  localparam int BIT_BP_B = 1;
  localparam int BIT_BAY_CLK_LO = 2;
  localparam int BIT_LOAD_PWR = 0;
  localparam int BIT_LINK = 1;
  localparam int BIT_STBY_PWR = 2;
  localparam int BIT_BAY_EN = 3;
  localparam int BIT_LOAD_FLT = 4;
  localparam int BIT_ISO_RDY = 5;
  localparam int BIT_STBY_GOOD = 6;
  localparam int BIT_STBY_FLT = 7;
  localparam int BIT_R_ISO_RDY = 0;
  localparam int BIT_R_LINK = 1;
  localparam int BIT_R_PRESENT = 2;
  localparam int BIT_R_PANEL_RST = 3;
  localparam int BIT_R_REAR_MODULE_RESET_N = 4;
  localparam int BIT_R_IRQ = 5;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] CLK_RESET = 8'h00;    // All clocks off.
  localparam logic [7:0] CLK_MASK = 8'h3f;     // Bits 7:6 unused.
  localparam logic [7:0] BAY_RESET = 8'h0c;    // Load power on, standby off, isolated, disabled.
  localparam logic [7:0] BAY_OUT_MASK = 8'h0f;
  localparam logic [7:0] REAR_RESET = 8'h00;   // Link off, rear module held in reset.
  localparam logic [7:0] REAR_OUT_MASK = 8'h12;

  // Local management addresses by bay.
  localparam logic [7:0] GEO_ADDR [4] = '{8'h7a, 8'h7c, 8'h7e, 8'h80};

  // Byte engine states.
  typedef enum logic [2:0] {
    BCCE_IDLE = 3'b000,
    BCCE_ADDR = 3'b001,
    BCCE_AACK = 3'b010,
    BCCE_WDAT = 3'b011,
    BCCE_WACK = 3'b100,
    BCCE_RDAT = 3'b101,
    BCCE_RACK = 3'b110,
    BCCE_SKIP = 3'b111
  } bcce_state_e;

endpackage : bcce_pkg

// File: rtl/bcce_i2c_slave.sv
// Small byte-wide I2C slave engine that serves a set of one-byte ports.
`timescale 1ns/1ps
module bcce_i2c_slave #(
  parameter int NPORT = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  input wire logic [NPORT*7-1:0] port_addr,
  input wire logic [NPORT*8-1:0] port_rdata,
  output logic [NPORT-1:0] port_wr,
  output logic [7:0] wdata
);

  // A port count outside 1 to 8 is refused at elaboration.
  if (NPORT < 1 || NPORT > 8) begin : g_bad_nport
    $error("NPORT out of range");
  end

  bcce_pkg::bcce_state_e state;
  logic scl_d;
  logic sda_d;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [NPORT-1:0] hit;
  logic [NPORT-1:0] sel;
  logic [7:0] rsel;
  logic is_read;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_in && !scl_d;
  assign scl_fall = !scl_in && scl_d;
  assign start_c = scl_in && scl_d && sda_d && !sda_in;
  assign stop_c = scl_in && scl_d && !sda_d && sda_in;

  // Address match per port; after eight bits the address sits in [7:1], R/W in [0].
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_hit
      assign hit[g] = (shreg[7:1] == port_addr[g*7 +: 7]);
    end
  endgenerate

  // Read data of the selected port.
  always_comb begin
    rsel = 8'h00;
    for (int i = 0; i < NPORT; i++) begin
      if (sel[i]) rsel = port_rdata[i*8 +: 8];
    end
  end

  // Line history for edge and condition detection.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  // Protocol engine; a start anywhere restarts it, so repeated start works.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= bcce_pkg::BCCE_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      sel <= '0;
      is_read <= 1'b0;
      sda_oe <= 1'b0;
      port_wr <= '0;
      wdata <= 8'h00;
    end else begin
      port_wr <= '0;
      if (start_c) begin
        state <= bcce_pkg::BCCE_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= bcce_pkg::BCCE_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          bcce_pkg::BCCE_IDLE, bcce_pkg::BCCE_SKIP: begin
            sda_oe <= 1'b0;
          end
          bcce_pkg::BCCE_ADDR, bcce_pkg::BCCE_WDAT: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_in};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              if (state == bcce_pkg::BCCE_ADDR) begin
                if (|hit) begin
                  sel <= hit;
                  is_read <= shreg[0];
                  sda_oe <= 1'b1;
                  state <= bcce_pkg::BCCE_AACK;
                end else begin
                  state <= bcce_pkg::BCCE_SKIP;
                end
              end else begin
                wdata <= shreg;
                port_wr <= sel;
                sda_oe <= 1'b1;
                state <= bcce_pkg::BCCE_WACK;
              end
            end
          end
          bcce_pkg::BCCE_AACK, bcce_pkg::BCCE_WACK: begin
            if (scl_fall) begin
              if (is_read) begin
                shreg <= rsel;
                sda_oe <= !rsel[7];
                bitcnt <= 4'h1;
                state <= bcce_pkg::BCCE_RDAT;
              end else begin
                sda_oe <= 1'b0;
                state <= bcce_pkg::BCCE_WDAT;
              end
            end
          end
          bcce_pkg::BCCE_RDAT: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= bcce_pkg::BCCE_RACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= !shreg[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          bcce_pkg::BCCE_RACK: begin
            if (scl_rise) begin
              if (sda_in) begin
                state <= bcce_pkg::BCCE_SKIP;
              end else begin
                state <= bcce_pkg::BCCE_AACK;
              end
            end
          end
        endcase
      end
    end
  end

endmodule : bcce_i2c_slave

// File: rtl/bcce_top.sv
// Bay and clock control ports: two I2C slaves serving eight one-byte ports.
`timescale 1ns/1ps
module bcce_top #(
  parameter int NBAY = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_scl,
  input wire logic clk_sda_in,
  output logic clk_sda_out,
  output logic clk_sda_oe,
  input wire logic bay_scl,
  input wire logic bay_sda_in,
  output logic bay_sda_out,
  output logic bay_sda_oe,
  output logic bp_clock1_a_drive_en,
  output logic bp_clock1_b_drive_en,
  output logic bp_clock2_a_drive_en,
  output logic bp_clock2_b_drive_en,
  output logic bp_clock3_a_drive_en,
  output logic bp_clock3_b_drive_en,
  output logic [3:0] bay_clock1_en,
  output logic [3:0] bay_clock2_en,
  output logic [3:0] bay_clock3_en,
  output logic [3:0] bay_load_power_en_n,
  output logic [3:0] bay_mgmt_link_connect,
  output logic [3:0] bay_standby_power_en_n,
  output logic [3:0] bay_enable_n,
  input wire logic [3:0] bay_load_power_fault_n,
  input wire logic [3:0] bay_isolator_ready,
  input wire logic [3:0] bay_standby_power_good,
  input wire logic [3:0] bay_standby_power_fault_n,
  output logic [31:0] bay_geo_local_addr,
  input wire logic rear_isolator_ready,
  output logic rear_mgmt_link_connect,
  input wire logic rear_module_present_n,
  input wire logic rear_panel_reset_n,
  output logic rear_module_reset_n,
  input wire logic rear_module_irq_n
);

  // The port map serves exactly four bays, so any other count is refused at elaboration.
  if (NBAY != 4) begin : g_bad_nbay
    $error("NBAY must be 4");
  end

  // ----------------------------------------
  // Port storage
  // ----------------------------------------
  // Only writable bits are stored; unused and input bits never hold state.
  logic [7:0] clk_port [3];
  logic [7:0] bay_port [4];
  logic [7:0] rear_port;
  logic [2:0] clk_wr;
  logic [4:0] bay_wr;
  logic [7:0] clk_wdata;
  logic [7:0] bay_wdata;
  logic [23:0] clk_rdata;
  logic [39:0] bay_rdata;
  logic [20:0] clk_addrs;
  logic [34:0] bay_addrs;
  logic clk_oe;
  logic bay_oe;

  assign clk_addrs = {bcce_pkg::ADDR_CLK3, bcce_pkg::ADDR_CLK2, bcce_pkg::ADDR_CLK1};
  assign bay_addrs = {bcce_pkg::ADDR_REAR, bcce_pkg::ADDR_BAY4, bcce_pkg::ADDR_BAY3,
                      bcce_pkg::ADDR_BAY2, bcce_pkg::ADDR_BAY1};

  // ----------------------------------------
  // Slave engines, one per private bus
  // ----------------------------------------
  bcce_i2c_slave #(.NPORT(3)) u_clk_slave (
    .clock(clock),
    .rst_n(rst_n),
    .scl_in(clk_scl),
    .sda_in(clk_sda_in),
    .sda_oe(clk_oe),
    .port_addr(clk_addrs),
    .port_rdata(clk_rdata),
    .port_wr(clk_wr),
    .wdata(clk_wdata)
  );

  bcce_i2c_slave #(.NPORT(5)) u_bay_slave (
    .clock(clock),
    .rst_n(rst_n),
    .scl_in(bay_scl),
    .sda_in(bay_sda_in),
    .sda_oe(bay_oe),
    .port_addr(bay_addrs),
    .port_rdata(bay_rdata),
    .port_wr(bay_wr),
    .wdata(bay_wdata)
  );

  // Clock fan-out ports keep bits 5:0 and drop writes to 7:6.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) clk_port[i] <= bcce_pkg::CLK_RESET;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (clk_wr[i]) clk_port[i] <= clk_wdata & bcce_pkg::CLK_MASK;
      end
    end
  end

  // Bay ports store only their four control bits.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) bay_port[i] <= bcce_pkg::BAY_RESET;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (bay_wr[i]) bay_port[i] <= bay_wdata & bcce_pkg::BAY_OUT_MASK;
      end
    end
  end

  // Rear port stores the link connect and module reset bits.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rear_port <= bcce_pkg::REAR_RESET;
    end else if (bay_wr[4]) begin
      rear_port <= bay_wdata & bcce_pkg::REAR_OUT_MASK;
    end
  end

  // ----------------------------------------
  // Read-back paths
  // ----------------------------------------
  // Clock ports read back what was written; bits 7:6 are already zero.
  always_comb begin
    for (int i = 0; i < 3; i++) clk_rdata[i*8 +: 8] = clk_port[i];
  end

  // Bay reads merge stored controls with live status inputs.
  // The isolator ready level is passed raw, since its polarity is not settled.
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bay_rd
      assign bay_rdata[b*8 +: 8] = {bay_standby_power_fault_n[b],
                                    bay_standby_power_good[b],
                                    bay_isolator_ready[b],
                                    bay_load_power_fault_n[b],
                                    bay_port[b][3:0]};
    end
  endgenerate

  assign bay_rdata[39:32] = {2'b00,
                             rear_module_irq_n,
                             rear_port[bcce_pkg::BIT_R_REAR_MODULE_RESET_N],
                             rear_panel_reset_n,
                             rear_module_present_n,
                             rear_port[bcce_pkg::BIT_R_LINK],
                             rear_isolator_ready};

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Output pins are copied through one flop so every output is a register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bp_clock1_a_drive_en <= 1'b0;
      bp_clock1_b_drive_en <= 1'b0;
      bp_clock2_a_drive_en <= 1'b0;
      bp_clock2_b_drive_en <= 1'b0;
      bp_clock3_a_drive_en <= 1'b0;
      bp_clock3_b_drive_en <= 1'b0;
      bay_clock1_en <= 4'h0;
      bay_clock2_en <= 4'h0;
      bay_clock3_en <= 4'h0;
    end else begin
      bp_clock1_a_drive_en <= clk_port[0][bcce_pkg::BIT_BP_A];
      bp_clock1_b_drive_en <= clk_port[0][bcce_pkg::BIT_BP_B];
      bp_clock2_a_drive_en <= clk_port[1][bcce_pkg::BIT_BP_A];
      bp_clock2_b_drive_en <= clk_port[1][bcce_pkg::BIT_BP_B];
      bp_clock3_a_drive_en <= clk_port[2][bcce_pkg::BIT_BP_A];
      bp_clock3_b_drive_en <= clk_port[2][bcce_pkg::BIT_BP_B];
      bay_clock1_en <= clk_port[0][bcce_pkg::BIT_BAY_CLK_LO +: 4];
      bay_clock2_en <= clk_port[1][bcce_pkg::BIT_BAY_CLK_LO +: 4];
      bay_clock3_en <= clk_port[2][bcce_pkg::BIT_BAY_CLK_LO +: 4];
    end
  end

  // Bay control pins; reset leaves load power on, standby power off, every bay isolated and disabled.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Matches the stored reset bit, so the power pin does not toggle after reset.
      bay_load_power_en_n <= {4{bcce_pkg::BAY_RESET[bcce_pkg::BIT_LOAD_PWR]}};
      bay_mgmt_link_connect <= 4'h0;
      bay_standby_power_en_n <= 4'hf;
      bay_enable_n <= 4'hf;
      bay_geo_local_addr <= 32'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        bay_load_power_en_n[i] <= bay_port[i][bcce_pkg::BIT_LOAD_PWR];
        bay_mgmt_link_connect[i] <= bay_port[i][bcce_pkg::BIT_LINK];
        bay_standby_power_en_n[i] <= bay_port[i][bcce_pkg::BIT_STBY_PWR];
        bay_enable_n[i] <= bay_port[i][bcce_pkg::BIT_BAY_EN];
        bay_geo_local_addr[i*8 +: 8] <= bcce_pkg::GEO_ADDR[i];
      end
    end
  end

  // Rear pins and the open-drain data lines.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rear_mgmt_link_connect <= 1'b0;
      rear_module_reset_n <= 1'b0;
      clk_sda_out <= 1'b0;
      clk_sda_oe <= 1'b0;
      bay_sda_out <= 1'b0;
      bay_sda_oe <= 1'b0;
    end else begin
      rear_mgmt_link_connect <= rear_port[bcce_pkg::BIT_R_LINK];
      rear_module_reset_n <= rear_port[bcce_pkg::BIT_R_REAR_MODULE_RESET_N];
      clk_sda_out <= 1'b0;
      clk_sda_oe <= clk_oe;
      bay_sda_out <= 1'b0;
      bay_sda_oe <= bay_oe;
    end
  end

endmodule : bcce_top

// File: dv/bcce_i2c_master.sv
// Behavioural I2C master standing in for the board management controller.
`timescale 1ns/1ps
module bcce_i2c_master (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // ----------------------------------------
  // Bit, byte and transfer tasks
  // ----------------------------------------
  // The bus idles released, so the pulled-up lines read high.
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Each phase lasts four clocks, above the three clocks of SCL high the slave needs.
  task automatic tick();
    repeat (4) @(posedge clock);
    #1;
  endtask : tick
  task automatic put_bit(input logic b);
    tick();
    sda_oe = ~b;
    tick();
    scl = 1'b1;
    tick();
    scl = 1'b0;
  endtask : put_bit
  // Releases SDA so the slave may answer; the level is taken late in SCL high.
  task automatic get_bit(output logic b);
    tick();
    sda_oe = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    b = sda;
    scl = 1'b0;
  endtask : get_bit
  task automatic send_byte(input logic [7:0] d, output logic n);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(n);
  endtask : send_byte
  // Start when st is 1, stop when 0; the start or stop edge of SDA comes while SCL is high.
  task automatic start_stop(input logic st);
    tick();
    sda_oe = ~st;
    tick();
    scl = 1'b1;
    tick();
    sda_oe = st;
    tick();
    scl = ~st;
  endtask : start_stop
  // One address byte and one data byte, each answered by the slave.
  task automatic write_port(input logic [6:0] a, input logic [7:0] d, output logic [1:0] n);
    start_stop(1'b1);
    send_byte({a, 1'b0}, n[1]);
    send_byte(d, n[0]);
    start_stop(1'b0);
  endtask : write_port
  // The master refuses the byte after the first so the slave lets go of SDA.
  task automatic read_port(input logic [6:0] a, output logic [7:0] d, output logic n);
    start_stop(1'b1);
    send_byte({a, 1'b1}, n);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    start_stop(1'b0);
  endtask : read_port
endmodule : bcce_i2c_master

// File: dv/bcce_monitor.sv
// Checker of the port behaviour of the bay and clock control block.
`timescale 1ns/1ps
module bcce_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_scl,
  input wire logic clk_sda_out,
  input wire logic clk_sda_oe,
  input wire logic bay_scl,
  input wire logic bay_sda_out,
  input wire logic bay_sda_oe,
  input wire logic bp_clock1_a_drive_en,
  input wire logic bp_clock1_b_drive_en,
  input wire logic bp_clock2_a_drive_en,
  input wire logic bp_clock2_b_drive_en,
  input wire logic bp_clock3_a_drive_en,
  input wire logic bp_clock3_b_drive_en,
  input wire logic [3:0] bay_clock1_en,
  input wire logic [3:0] bay_clock2_en,
  input wire logic [3:0] bay_clock3_en,
  input wire logic [3:0] bay_load_power_en_n,
  input wire logic [3:0] bay_mgmt_link_connect,
  input wire logic [3:0] bay_standby_power_en_n,
  input wire logic [3:0] bay_enable_n,
  input wire logic [31:0] bay_geo_local_addr,
  input wire logic rear_mgmt_link_connect,
  input wire logic rear_module_reset_n
);
  // ----------------------------------------
  // Helper logic and properties
  // ----------------------------------------
  logic [1:0] up;
  logic [5:0] cpair;
  logic [11:0] cbay;
  logic [15:0] bo;
  logic [1:0] ro;
  // Edges since reset, so the load of reset values is not taken for a write.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  // Output groups by bus.
  assign cpair = {bp_clock3_b_drive_en, bp_clock3_a_drive_en, bp_clock2_b_drive_en,
                  bp_clock2_a_drive_en, bp_clock1_b_drive_en, bp_clock1_a_drive_en};
  assign cbay = {bay_clock3_en, bay_clock2_en, bay_clock1_en};
  assign bo = {bay_enable_n, bay_standby_power_en_n, bay_mgmt_link_connect, bay_load_power_en_n};
  assign ro = {rear_mgmt_link_connect, rear_module_reset_n};
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_geo_fixed: assert property (up != 2'h0 |->
    bay_geo_local_addr == 32'h807e7c7a) else $error("geo address wrong");
  chk_reset_state: assert property (up == 2'h2 |-> {cpair, cbay} == 18'h0 &&
    bo == 16'hff00 && ro == 2'b00) else $error("state after reset wrong");
  chk_pair_cause: assert property (up == 2'h3 && $changed(cpair) |->
    $past(clk_sda_oe, 1) || $past(clk_sda_oe, 2) || $past(clk_sda_oe, 3))
    else $error("backplane enable moved without a write");
  chk_bayclk_cause: assert property (up == 2'h3 && $changed(cbay) |->
    $past(clk_sda_oe, 1) || $past(clk_sda_oe, 2) || $past(clk_sda_oe, 3))
    else $error("bay clock enable moved without a write");
  chk_bay_cause: assert property (up == 2'h3 && $changed(bo) |->
    $past(bay_sda_oe, 1) || $past(bay_sda_oe, 2) || $past(bay_sda_oe, 3))
    else $error("bay control moved without a write");
  chk_rear_cause: assert property (up == 2'h3 && $changed(ro) |->
    $past(bay_sda_oe, 1) || $past(bay_sda_oe, 2) || $past(bay_sda_oe, 3))
    else $error("rear control moved without a write");
  chk_open_drain: assert property (clk_sda_out == 1'b0 && bay_sda_out == 1'b0)
    else $error("data line driven high");
  chk_clk_sda_move: assert property ($changed(clk_sda_oe) |-> !clk_scl)
    else $error("clock bus data moved with SCL high");
  chk_bay_sda_move: assert property ($changed(bay_sda_oe) |-> !bay_scl)
    else $error("bay bus data moved with SCL high");
  cov_clk_write: cover property (up == 2'h3 && $changed(cbay));
  cov_bay_write: cover property (up == 2'h3 && $changed(bo));
  cov_rear_write: cover property ($rose(rear_module_reset_n));
endmodule : bcce_monitor

bind bcce_top bcce_monitor u_mon (
  .clock, .rst_n, .clk_scl, .clk_sda_out, .clk_sda_oe, .bay_scl, .bay_sda_out, .bay_sda_oe,
  .bp_clock1_a_drive_en, .bp_clock1_b_drive_en, .bp_clock2_a_drive_en,
  .bp_clock2_b_drive_en, .bp_clock3_a_drive_en, .bp_clock3_b_drive_en,
  .bay_clock1_en, .bay_clock2_en, .bay_clock3_en, .bay_load_power_en_n,
  .bay_mgmt_link_connect, .bay_standby_power_en_n, .bay_enable_n, .bay_geo_local_addr,
  .rear_mgmt_link_connect, .rear_module_reset_n
);

// File: dv/bcce_top_tb.sv
// Self-checking testbench of the bay and clock control block.
`timescale 1ns/1ps
module bcce_top_tb;
  // ----------------------------------------
  // Signals, clock and instances
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_scl, bay_scl, cm_oe, bm_oe, clk_sda_out, clk_sda_oe, bay_sda_out, bay_sda_oe;
  logic bp_clock1_a_drive_en, bp_clock1_b_drive_en, bp_clock2_a_drive_en;
  logic bp_clock2_b_drive_en, bp_clock3_a_drive_en, bp_clock3_b_drive_en;
  logic [3:0] bay_clock1_en, bay_clock2_en, bay_clock3_en, bay_load_power_en_n;
  logic [3:0] bay_mgmt_link_connect, bay_standby_power_en_n, bay_enable_n;
  logic [31:0] bay_geo_local_addr;
  logic rear_mgmt_link_connect, rear_module_reset_n;
  logic [3:0] bay_load_power_fault_n = 4'ha;
  logic [3:0] bay_isolator_ready = 4'h6;
  logic [3:0] bay_standby_power_good = 4'h3;
  logic [3:0] bay_standby_power_fault_n = 4'hc;
  logic rear_isolator_ready = 1'b1;
  logic rear_module_present_n = 1'b0;
  logic rear_panel_reset_n = 1'b1;
  logic rear_module_irq_n = 1'b0;
  logic [5:0] clk_out [3];
  int miscompares = 0;
  int checks = 0;
  // Both data lines are pulled up and pulled low by whichever party enables.
  wire clk_sda_in = ~(cm_oe | clk_sda_oe);
  wire bay_sda_in = ~(bm_oe | bay_sda_oe);
  assign clk_out[0] = {bay_clock1_en, bp_clock1_b_drive_en, bp_clock1_a_drive_en};
  assign clk_out[1] = {bay_clock2_en, bp_clock2_b_drive_en, bp_clock2_a_drive_en};
  assign clk_out[2] = {bay_clock3_en, bp_clock3_b_drive_en, bp_clock3_a_drive_en};
  // Half period of 20 ns gives 25 MHz.
  always #20 clock = ~clock;
  bcce_top dut (
    .clock, .rst_n, .clk_scl, .clk_sda_in, .clk_sda_out, .clk_sda_oe, .bay_scl, .bay_sda_in,
    .bay_sda_out, .bay_sda_oe, .bp_clock1_a_drive_en, .bp_clock1_b_drive_en,
    .bp_clock2_a_drive_en, .bp_clock2_b_drive_en, .bp_clock3_a_drive_en,
    .bp_clock3_b_drive_en, .bay_clock1_en, .bay_clock2_en, .bay_clock3_en,
    .bay_load_power_en_n, .bay_mgmt_link_connect, .bay_standby_power_en_n, .bay_enable_n,
    .bay_load_power_fault_n, .bay_isolator_ready, .bay_standby_power_good,
    .bay_standby_power_fault_n, .bay_geo_local_addr, .rear_isolator_ready,
    .rear_mgmt_link_connect, .rear_module_present_n, .rear_panel_reset_n,
    .rear_module_reset_n, .rear_module_irq_n
  );
  bcce_i2c_master m_clk (.clock, .sda(clk_sda_in), .scl(clk_scl), .sda_oe(cm_oe));
  bcce_i2c_master m_bay (.clock, .sda(bay_sda_in), .scl(bay_scl), .sda_oe(bm_oe));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    checks++;
    if (act !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // The acknowledge bits are compared together with every transfer.
  task automatic wr(input logic bus, input logic [6:0] a, input logic [7:0] d,
                    input logic [1:0] en);
    logic [1:0] n;
    if (bus) begin
      m_bay.write_port(a, d, n);
    end else begin
      m_clk.write_port(a, d, n);
    end
    check(32'(n), 32'(en));
  endtask : wr
  task automatic rd(input logic bus, input logic [6:0] a, input logic [7:0] ed, input logic en);
    logic [7:0] d;
    logic n;
    if (bus) begin
      m_bay.read_port(a, d, n);
    end else begin
      m_clk.read_port(a, d, n);
    end
    check(32'({n, d}), 32'({en, ed}));
  endtask : rd
  // Status inputs are inverted so that read bits are seen to follow live levels.
  task automatic flip();
    @(posedge clock);
    #1;
    bay_load_power_fault_n = ~bay_load_power_fault_n;
    bay_isolator_ready = ~bay_isolator_ready;
    bay_standby_power_good = ~bay_standby_power_good;
    bay_standby_power_fault_n = ~bay_standby_power_fault_n;
    rear_isolator_ready = ~rear_isolator_ready;
    rear_module_present_n = ~rear_module_present_n;
    rear_panel_reset_n = ~rear_panel_reset_n;
    rear_module_irq_n = ~rear_module_irq_n;
  endtask : flip
  function automatic logic [7:0] bay_exp(input int i, input logic [7:0] w);
    return {bay_standby_power_fault_n[i], bay_standby_power_good[i], bay_isolator_ready[i],
            bay_load_power_fault_n[i], w[3:0]};
  endfunction : bay_exp
  function automatic logic [3:0] bay_nib(input int i);
    return {bay_enable_n[i], bay_standby_power_en_n[i], bay_mgmt_link_connect[i],
            bay_load_power_en_n[i]};
  endfunction : bay_nib
  function automatic logic [7:0] rear_exp(input logic [7:0] w);
    return {2'b00, rear_module_irq_n, w[4], rear_panel_reset_n, rear_module_present_n, w[1],
            rear_isolator_ready};
  endfunction : rear_exp
  // ----------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------
  // Clock ports first, then unmatched addresses, bay ports and the rear port.
  initial begin
    logic [7:0] p [3];
    logic [6:0] a;
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clock);
    check(bay_geo_local_addr, 32'h807e7c7a);
    for (int k = 0; k < 3; k++) begin
      a = bcce_pkg::ADDR_CLK1 + 7'(k);
      rd(1'b0, a, bcce_pkg::CLK_RESET, 1'b0);
      p = '{8'hff, 8'h15, 8'hea};
      foreach (p[j]) begin
        wr(1'b0, a, p[j], 2'b00);
        check(32'(clk_out[k]), 32'(p[j][5:0]));
        rd(1'b0, a, p[j] & 8'h3f, 1'b0);
      end
    end
    check(32'({rear_mgmt_link_connect, rear_module_reset_n}), 32'h0);
    wr(1'b0, 7'h1f, 8'h00, 2'b11);
    rd(1'b1, 7'h1f, 8'hff, 1'b1);
    check(32'({clk_out[0], clk_out[1], clk_out[2]}), 32'h2aaaa);
    for (int i = 0; i < 4; i++) begin
      a = bcce_pkg::ADDR_BAY1 + 7'(i);
      rd(1'b1, a, bay_exp(i, bcce_pkg::BAY_RESET), 1'b0);
      p = '{8'hf5, 8'h0a, 8'h08 + 8'(i)};
      foreach (p[j]) begin
        wr(1'b1, a, p[j], 2'b00);
        check(32'(bay_nib(i)), 32'(p[j][3:0]));
        rd(1'b1, a, bay_exp(i, p[j]), 1'b0);
      end
    end
    check(32'({bay_enable_n, bay_standby_power_en_n, bay_mgmt_link_connect,
               bay_load_power_en_n}), 32'hf0ca);
    a = bcce_pkg::ADDR_REAR;
    rd(1'b1, a, rear_exp(bcce_pkg::REAR_RESET), 1'b0);
    p = '{8'hff, 8'h00, 8'h12};
    foreach (p[j]) begin
      wr(1'b1, a, p[j], 2'b00);
      check(32'({rear_module_reset_n, rear_mgmt_link_connect}),
            32'({p[j][4], p[j][1]}));
      rd(1'b1, a, rear_exp(p[j]), 1'b0);
      flip();
    end
    for (int i = 0; i < 4; i++) begin
      rd(1'b1, bcce_pkg::ADDR_BAY1 + 7'(i), bay_exp(i, 8'h08 + 8'(i)), 1'b0);
    end
    stop_test();
  end
  // About 15400 cycles are expected; the limit leaves ample margin.
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    stop_test();
  end
endmodule : bcce_top_tb
